// ---- rtl/ebd_top.sv ----
// ebd_top: external parallel bus interface with hold and dma slave
// assumes all pins synchronous to mclk_i; tristate resolved outside
// Functional notes
// - drive 16-bit address/data; one of three space selects, 64K each
// - io uses same buses and cycles, only io select differs
// - direction output says read or write every external cycle
// - strobe frames active part of every external cycle
// - separate read and write strobes active only for their cycle
// - internal and fast external accesses take no wait states
// - cycle stretched while ready inactive; resumes when sampled active
// - global data access asserts bus request low at access start
// - host may read and write internal ram over external bus
// - host requests hold first; device answers with hold acknowledge
// - plain hold lets cycle finish; cpu runs on if mode bit 0
// - dma bus request halts the current cpu operation only while hold is acknowledged
// - internal bus granted on third clock after bus request
// - grant indicator pin shows internal bus granted to host
// - hold low powers down core, peripherals run, ends on release
// - keeper variants hold last data level when bus undriven
// - global region top 256 to 32K data words, power-of-two sized
`timescale 1ns/100ps
module ebd_top #(
    parameter int RAM_DEPTH = 1024,
    parameter int RAM_AW = 10
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // core side
    input wire ebd_pkg::ebd_core_req_t core_req_i,
    input wire logic core_internal_i,
    input wire logic surrender_mode_bit_i,
    input wire logic [ebd_pkg::EBD_GSZ_W-1:0] global_region_size_reg_i,
    output logic core_done_o,
    output logic [ebd_pkg::EBD_DW-1:0] core_rdata_o,
    output logic core_stall_o,
    output logic core_power_down_o,
    // external pins
    output ebd_pkg::ebd_pins_t pins_o,
    input wire logic [ebd_pkg::EBD_DW-1:0] data_i,
    input wire logic ready_i,
    input wire logic hold_n_i,
    output logic surrender_acknowledge_n_o,
    input wire logic global_bus_request_n_i,
    output logic global_bus_request_n_o,
    output logic global_bus_request_oe_o,
    output logic access_grant_indicator_o,
    // host dma into internal ram
    input wire ebd_pkg::ebd_dma_req_t dma_req_i,
    output logic [ebd_pkg::EBD_DW-1:0] dma_rdata_o,
    // internal ram port for core
    input wire logic ram_core_we_i,
    input wire logic [RAM_AW-1:0] ram_core_addr_i,
    input wire logic [ebd_pkg::EBD_DW-1:0] ram_core_wdata_i,
    output logic [ebd_pkg::EBD_DW-1:0] ram_core_rdata_o
);
    import ebd_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    ebd_bus_st_t st_q;
    ebd_bus_st_t st_d;
    ebd_pins_t pins_q;
    ebd_pins_t pins_d;
    logic glob_q;
    logic glob_d;
    logic surrender_acknowledge_n_q;
    logic surrender_acknowledge_n_d;
    logic [EBD_DW-1:0] rdata_q;
    logic [EBD_DW-1:0] rdata_d;
    logic [EBD_DW-1:0] keep_q;
    logic [EBD_DW-1:0] keep_d;
    logic done_q;
    logic done_d;
    logic dma_halt;
    logic dma_grant;
    logic is_glob;
    logic ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [EBD_DW-1:0] ram_wdata;
    logic [EBD_DW-1:0] ram_rdata;

    // decode of the global region from the size register
    assign is_glob = (core_req_i.space == EBD_SP_DATA) &&
                     ebd_is_global(core_req_i.addr,
                                   global_region_size_reg_i);

    // ************************************************************
    // dma grant sequencer
    // ************************************************************
    ebd_grant u_grant (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .req_n_i(global_bus_request_n_i | surrender_acknowledge_n_o),
        .halt_o(dma_halt),
        .grant_o(dma_grant)
    );

    // ************************************************************
    // external cycle sequencer
    // ************************************************************
    always_comb begin
        st_d = st_q;
        pins_d = pins_q;
        glob_d = glob_q;
        surrender_acknowledge_n_d = surrender_acknowledge_n_q;
        rdata_d = rdata_q;
        keep_d = keep_q;
        done_d = 1'b0;
        unique case (st_q)
            EBD_ST_IDLE: begin
                // hold acknowledged only between cycles
                surrender_acknowledge_n_d = !hold_n_i;
                if (hold_n_i && !surrender_acknowledge_n_q && core_req_i.req &&
                    !core_internal_i && !dma_halt) begin
                    st_d = EBD_ST_CYCLE;
                    pins_d.addr = core_req_i.addr;
                    pins_d.data = core_req_i.wdata;
                    pins_d.data_oe = core_req_i.wr;
                    // io differs only by its select
                    pins_d.program_space_select_n =
                        (core_req_i.space != EBD_SP_PROG);
                    pins_d.data_space_select_n =
                        (core_req_i.space != EBD_SP_DATA);
                    pins_d.io_space_select_n =
                        (core_req_i.space != EBD_SP_IO);
                    pins_d.rd_wr_n = !core_req_i.wr;
                    pins_d.external_cycle_strobe_n = 1'b0;
                    pins_d.rd_n = core_req_i.wr;
                    pins_d.we_n = !core_req_i.wr;
                    glob_d = is_glob;
                end
            end
            EBD_ST_CYCLE: begin
                // stretch until ready sampled active
                if (ready_i) begin
                    st_d = EBD_ST_DONE;
                    rdata_d = data_i;
                    if (!pins_q.data_oe) begin
                        keep_d = data_i;
                    end
                    done_d = 1'b1;
                    pins_d.external_cycle_strobe_n = 1'b1;
                    pins_d.rd_n = 1'b1;
                    pins_d.we_n = 1'b1;
                    glob_d = 1'b0;
                end
            end
            EBD_ST_DONE: begin
                st_d = EBD_ST_IDLE;
                if (pins_q.data_oe) begin
                    keep_d = pins_q.data;
                end
                pins_d.data_oe = 1'b0;
                pins_d.program_space_select_n = 1'b1;
                pins_d.data_space_select_n = 1'b1;
                pins_d.io_space_select_n = 1'b1;
                pins_d.rd_wr_n = 1'b1;
            end
            default: begin
                st_d = EBD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= EBD_ST_IDLE;
            pins_q <= '{addr: EBD_ADDR_ZERO, data: EBD_DATA_ZERO,
                        data_oe: 1'b0, program_space_select_n: 1'b1,
                        data_space_select_n: 1'b1,
                        io_space_select_n: 1'b1, rd_wr_n: 1'b1,
                        external_cycle_strobe_n: 1'b1, rd_n: 1'b1,
                        we_n: 1'b1, ctl_oe: 1'b1};
            glob_q <= 1'b0;
            surrender_acknowledge_n_q <= 1'b0;
            rdata_q <= EBD_DATA_ZERO;
            keep_q <= EBD_DATA_ZERO;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pins_q <= pins_d;
            glob_q <= glob_d;
            surrender_acknowledge_n_q <= surrender_acknowledge_n_d;
            rdata_q <= rdata_d;
            keep_q <= keep_d;
            done_q <= done_d;
        end
    end

    // ************************************************************
    // pin outputs; float everything under hold acknowledge
    // ************************************************************
    always_comb begin
        pins_o = pins_q;
        pins_o.ctl_oe = !surrender_acknowledge_n_q;
        pins_o.data_oe = pins_q.data_oe && !surrender_acknowledge_n_q;
        // keeper: last driven or sampled level when nobody drives
        if (!pins_q.data_oe) begin
            pins_o.data = keep_q;
        end
    end

    assign surrender_acknowledge_n_o = !surrender_acknowledge_n_q;
    // shared line: device drives it low only for its own global access
    assign global_bus_request_n_o = 1'b0;
    assign global_bus_request_oe_o = glob_q && !surrender_acknowledge_n_q;
    assign access_grant_indicator_o = dma_grant;

    // ************************************************************
    // core status
    // ************************************************************
    assign core_done_o = done_q;
    assign core_rdata_o = rdata_q;
    // internal accesses wait only on a dma halt or a hold with mode bit 1
    // plain hold stalls only external work when mode bit is 0
    assign core_stall_o = dma_halt ||
                          (surrender_acknowledge_n_q && surrender_mode_bit_i) ||
                          (core_req_i.req && !core_internal_i &&
                           !done_q);
    assign core_power_down_o = !hold_n_i;

    // ************************************************************
    // single access ram, host owns the port once granted
    // ************************************************************
    assign ram_we = dma_grant ? dma_req_i.req && dma_req_i.wr
                              : ram_core_we_i;
    assign ram_addr = dma_grant ? dma_req_i.addr[RAM_AW-1:0]
                                : ram_core_addr_i;
    assign ram_wdata = dma_grant ? dma_req_i.wdata : ram_core_wdata_i;
    assign dma_rdata_o = ram_rdata;
    assign ram_core_rdata_o = ram_rdata;  // core resumes as left

    ebd_ram #(
        .DEPTH(RAM_DEPTH),
        .AW(RAM_AW),
        .DW(EBD_DW)
    ) u_ram (
        .mclk_i(mclk_i),
        .we_i(ram_we),
        .addr_i(ram_addr),
        .wdata_i(ram_wdata),
        .rdata_o(ram_rdata)
    );
endmodule

// ---- rtl/ebd_pkg.sv ----
// ebd_pkg: shared types and constants of the external bus and dma slave
// assumes a single 125 MHz machine clock and active low async reset
package ebd_pkg;

    // ************************************************************
    // widths and sizes
    // ************************************************************
    localparam int EBD_AW = 16;
    localparam int EBD_DW = 16;
    localparam int EBD_GSZ_W = 8;            // region size register width
    localparam int EBD_GRANT_CYC = 3;        // grant on third clock after request
    localparam logic [1:0] EBD_GRANT_LAST = 2'h2;
    localparam logic [EBD_AW-1:0] EBD_ADDR_ZERO = 16'h0000;
    localparam logic [EBD_DW-1:0] EBD_DATA_ZERO = 16'h0000;
    localparam logic [EBD_GSZ_W-1:0] EBD_GSZ_ZERO = 8'h00;
    localparam logic [EBD_GSZ_W-1:0] EBD_GSZ_MIN = 8'h80;  // 32K words
    localparam int EBD_RAM_DEPTH = 1024;     // single access ram words
    localparam int EBD_RAM_AW = 10;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        EBD_SP_PROG = 2'h0,
        EBD_SP_DATA = 2'h1,
        EBD_SP_IO = 2'h2
    } ebd_space_t;

    // core request to the external bus
    typedef struct packed {
        logic req;
        logic wr;
        ebd_space_t space;
        logic [EBD_AW-1:0] addr;
        logic [EBD_DW-1:0] wdata;
    } ebd_core_req_t;

    // external pin bundle driven by the device
    typedef struct packed {
        logic [EBD_AW-1:0] addr;
        logic [EBD_DW-1:0] data;
        logic data_oe;
        logic program_space_select_n;
        logic data_space_select_n;
        logic io_space_select_n;
        logic rd_wr_n;
        logic external_cycle_strobe_n;
        logic rd_n;
        logic we_n;
        logic ctl_oe;
    } ebd_pins_t;

    // host dma access into internal ram
    typedef struct packed {
        logic req;
        logic wr;
        logic [EBD_AW-1:0] addr;
        logic [EBD_DW-1:0] wdata;
    } ebd_dma_req_t;

    typedef enum logic [1:0] {
        EBD_ST_IDLE = 2'h0,
        EBD_ST_CYCLE = 2'h1,
        EBD_ST_DONE = 2'h2
    } ebd_bus_st_t;

    // ************************************************************
    // global region decode: size register holds the high byte of the
    // region address mask (8'h80 is 32K words, 8'hFF is 256 words)
    // ************************************************************
    function automatic logic ebd_is_global(input logic [EBD_AW-1:0] a,
                                           input logic [EBD_GSZ_W-1:0] g);
        logic [EBD_AW-1:0] mask;
        mask = {g, EBD_GSZ_ZERO};
        ebd_is_global = (g >= EBD_GSZ_MIN) && ((a & mask) == mask);
    endfunction

endpackage

// ---- rtl/ebd_grant.sv ----
// ebd_grant: dma grant sequencer on the host bus request line
// assumes the request line is synchronous to mclk_i
`timescale 1ns/100ps
module ebd_grant (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_n_i,
    output logic halt_o,
    output logic grant_o
);
    import ebd_pkg::*;

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic grant_q;
    logic grant_d;

    // ************************************************************
    // count three clocks then grant
    // ************************************************************
    always_comb begin
        cnt_d = cnt_q;
        grant_d = grant_q;
        if (req_n_i) begin
            cnt_d = 2'h0;      // release withdraws the grant
            grant_d = 1'b0;
        end else if (!grant_q) begin
            if (cnt_q == EBD_GRANT_LAST) begin
                grant_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 2'h0;
            grant_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            grant_q <= grant_d;
        end
    end

    // halt is immediate: the cpu stops at once on a request
    assign halt_o = !req_n_i;
    assign grant_o = grant_q;
endmodule

// ---- rtl/ebd_ram.sv ----
// ebd_ram: single access internal ram, one port per cycle
// assumes the caller muxes core and dma onto its single port
`timescale 1ns/100ps
module ebd_ram #(
    parameter int DEPTH = 1024,
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_q;

    // ************************************************************
    // synchronous write and registered read
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_q <= mem[addr_i];
    end

    assign rdata_o = rdata_q;
endmodule

// ---- verif/ebd_top_assertions.sv ----
// checker on the ports of ebd_top, bound below its module
// assumes one clock domain and the pin bundle of ebd_pkg
`timescale 1ns/100ps
module ebd_top_assertions (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire ebd_pkg::ebd_core_req_t core_req_i,
    input wire logic ready_i,
    input wire logic [ebd_pkg::EBD_GSZ_W-1:0] global_region_size_reg_i,
    input wire logic core_done_o,
    input wire ebd_pkg::ebd_pins_t pins_o,
    input wire logic surrender_acknowledge_n_o,
    input wire logic global_bus_request_n_i,
    input wire logic global_bus_request_oe_o,
    input wire logic access_grant_indicator_o
);
    import ebd_pkg::*;
    // ************************************************************
    // pin relations
    // ************************************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic s_n;
    logic glob;
    logic gnt;
    // region decode kept apart from the design's own helper
    assign s_n = pins_o.external_cycle_strobe_n;
    assign gnt = access_grant_indicator_o;
    assign glob = core_req_i.space == EBD_SP_DATA
        && global_region_size_reg_i >= 8'h80
        && &(core_req_i.addr[15:8] | ~global_region_size_reg_i);
    a_rw_strobes:
        assert property (pins_o.rd_n == (s_n | ~pins_o.rd_wr_n)
            && pins_o.we_n == (s_n | pins_o.rd_wr_n))
        else $error("read or write strobe wrong");
    a_space_select:
        assert property (!s_n |-> pins_o.addr == core_req_i.addr
            && {pins_o.program_space_select_n, pins_o.data_space_select_n,
            pins_o.io_space_select_n} == ~(3'h4 >> core_req_i.space))
        else $error("space select or address wrong");
    a_ready_stretch:
        assert property (!s_n && !ready_i |=> !s_n)
        else $error("cycle ended without ready");
    a_ready_ends:
        assert property (!s_n && ready_i |=> s_n && core_done_o)
        else $error("cycle not closed after ready");
    a_global_request:
        assert property (!s_n |-> global_bus_request_oe_o == glob)
        else $error("global request wrong");
    a_float_hold:
        assert property (!surrender_acknowledge_n_o
            |-> !pins_o.ctl_oe && !pins_o.data_oe)
        else $error("pins driven under hold");
    a_grant_third:
        assert property ($fell(global_bus_request_n_i)
            && !surrender_acknowledge_n_o |=> !gnt ##1 !gnt ##1 gnt)
        else $error("grant not on third clock");
    a_grant_drop:
        assert property ($rose(global_bus_request_n_i) && gnt |=> !gnt)
        else $error("grant kept after release");
endmodule

bind ebd_top ebd_top_assertions u_ebd_top_assertions (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .core_req_i(core_req_i),
    .ready_i(ready_i), .global_region_size_reg_i(global_region_size_reg_i),
    .core_done_o(core_done_o), .pins_o(pins_o),
    .surrender_acknowledge_n_o(surrender_acknowledge_n_o),
    .global_bus_request_n_i(global_bus_request_n_i),
    .global_bus_request_oe_o(global_bus_request_oe_o),
    .access_grant_indicator_o(access_grant_indicator_o)
);

// ---- verif/ebd_far_model.sv ----
// far-side memory and io device with settable wait states
// assumes pins are sampled on the rising edge of mclk_i
`timescale 1ns/100ps
module ebd_far_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire ebd_pkg::ebd_pins_t pins_i,
    input wire logic gbr_oe_i,
    input wire logic [3:0] waits_i,
    output logic [ebd_pkg::EBD_DW-1:0] data_o,
    output logic ready_o
);
    import ebd_pkg::*;
    logic [EBD_DW-1:0] mem [0:255];
    logic [EBD_DW-1:0] last_q;
    logic [4:0] cnt_q;
    // ************************************************************
    // answer side
    // ************************************************************
    // global access holds ready back two more clocks for arbitration
    assign ready_o = !pins_i.external_cycle_strobe_n
        && cnt_q >= {1'b0, waits_i} + (gbr_oe_i ? 5'h02 : 5'h00);
    // a released bus moves every cycle so stale data cannot match
    assign data_o = (!pins_i.external_cycle_strobe_n && !pins_i.rd_n)
        ? mem[pins_i.addr[7:0]] : ~last_q;
    // wait counter, last bus value and write capture
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 5'h00;
            last_q <= 16'h0000;
        end else begin
            cnt_q <= pins_i.external_cycle_strobe_n ? 5'h00 : cnt_q + 5'h01;
            last_q <= data_o;
            if (ready_o && !pins_i.we_n) begin
                mem[pins_i.addr[7:0]] <= pins_i.data;
            end
        end
    end
endmodule

// ---- verif/test_ebd_top.sv ----
// self-checking bench for ebd_top with the far-side model
// assumes the model stores 256 words, shared by all spaces
`timescale 1ns/100ps
module test_ebd_top;
    import ebd_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    ebd_core_req_t core_req = '0;
    ebd_dma_req_t dma_req = '0;
    logic internal = 1'b0, mode = 1'b0, hold_n = 1'b1, host_n = 1'b1;
    logic [7:0] gsz = 8'h00;
    logic [3:0] waits = 4'h0;
    logic ram_we = 1'b0;
    logic [9:0] ram_a = 10'h000;
    logic [15:0] ram_wd = 16'h0000;
    ebd_pins_t pins;
    logic done, stall, pdown, surrender_acknowledge_n_n, gbr_n, gbr_oe, gnt, rdy, line;
    logic [15:0] rdat, dma_rd, ram_rd, mdat, dbus, rdv;
    logic [2:0] sel, es;
    logic rw, goe;
    int slo, n_mismatch = 0, total_checks = 0;
    // data and request lines resolved from every driver
    assign dbus = pins.data_oe ? pins.data : mdat;
    assign line = ~((gbr_oe & ~gbr_n) | ~host_n);
    ebd_top u_ebd_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .core_req_i(core_req), .core_internal_i(internal),
        .surrender_mode_bit_i(mode), .global_region_size_reg_i(gsz),
        .core_done_o(done), .core_rdata_o(rdat), .core_stall_o(stall),
        .core_power_down_o(pdown), .pins_o(pins), .data_i(dbus),
        .ready_i(rdy), .hold_n_i(hold_n),
        .surrender_acknowledge_n_o(surrender_acknowledge_n_n), .global_bus_request_n_i(line),
        .global_bus_request_n_o(gbr_n), .global_bus_request_oe_o(gbr_oe),
        .access_grant_indicator_o(gnt), .dma_req_i(dma_req),
        .dma_rdata_o(dma_rd), .ram_core_we_i(ram_we),
        .ram_core_addr_i(ram_a), .ram_core_wdata_i(ram_wd),
        .ram_core_rdata_o(ram_rd));
    ebd_far_model u_ebd_far_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .pins_i(pins), .gbr_oe_i(gbr_oe), .waits_i(waits), .data_o(mdat),
        .ready_o(rdy));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic nc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // bounded wait; running out ends the run as a failure
    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 20 && s !== v; i++) nc(1);
        if (s !== v) begin
            n_mismatch++;
            results();
        end
    endtask
    // one core cycle, held until done; records what the pins showed
    task automatic bus_op(input ebd_space_t sp, input logic wr,
        input logic [15:0] a, input logic [15:0] d);
        int i;
        slo = 0;
        core_req = '{1'b1, wr, sp, a, d};
        for (i = 0; i < 40 && done !== 1'b1; i++) begin
            nc(1);
            if (pins.external_cycle_strobe_n === 1'b0) begin
                slo++;
                sel = {pins.program_space_select_n,
                    pins.data_space_select_n, pins.io_space_select_n};
                rw = pins.rd_wr_n;
                goe = gbr_oe;
            end
        end
        if (i == 40) begin
            n_mismatch++;
            results();
        end
        rdv = rdat;
        core_req.req = 1'b0;
        nc(2);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_spaces;
        for (int s = 0; s < 3; s++) begin
            es = ~(3'h4 >> s);
            bus_op(ebd_space_t'(s), 1'b1, 16'h0020 + 16'(s), 16'hA500 + 16'(s));
            chk("sel", 16'(es), 16'(sel));
            chk("rw", 16'h0000, 16'(rw));
            chk("keep", 16'hA500 + 16'(s), pins.data);
            bus_op(ebd_space_t'(s), 1'b0, 16'h0020 + 16'(s), 16'h0000);
            chk("rdat", 16'hA500 + 16'(s), rdv);
            chk("rw", 16'h0001, 16'(rw));
        end
        $display("spaces done");
    endtask
    task automatic t_waits;
        for (int w = 0; w < 4; w += 3) begin
            waits = 4'(w);
            bus_op(EBD_SP_DATA, 1'b0, 16'h0021, 16'h0000);
            chk("strobe len", 16'(w + 1), 16'(slo));
        end
        waits = 4'h0;
        internal = 1'b1;
        core_req = '{1'b1, 1'b0, EBD_SP_DATA, 16'h0021, 16'h0000};
        nc(4);
        chk("internal", 16'h0001, 16'(pins.external_cycle_strobe_n));
        core_req.req = 1'b0;
        internal = 1'b0;
        nc(2);
        $display("waits done");
    endtask
    task automatic t_global;
        gsz = 8'hFF;
        bus_op(EBD_SP_DATA, 1'b1, 16'hFF10, 16'h1234);
        chk("glob", 16'h0001, 16'(goe));
        chk("glob len", 16'h0003, 16'(slo));
        bus_op(EBD_SP_DATA, 1'b1, 16'h7F10, 16'h1234);
        chk("local", 16'h0000, 16'(goe));
        bus_op(EBD_SP_PROG, 1'b0, 16'hFF10, 16'h0000);
        chk("prog", 16'h0000, 16'(goe));
        gsz = 8'h80;
        bus_op(EBD_SP_DATA, 1'b0, 16'h8000, 16'h0000);
        chk("glob32k", 16'h0001, 16'(goe));
        gsz = 8'h00;
        $display("global done");
    endtask
    task automatic t_hold;
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            hold_n = 1'b0;
            wait_lvl(surrender_acknowledge_n_n, 1'b0);
            chk("ctl_oe", 16'h0000, 16'(pins.ctl_oe));
            chk("pdown", 16'h0001, 16'(pdown));
            chk("stall", 16'(m), 16'(stall));
            hold_n = 1'b1;
            wait_lvl(surrender_acknowledge_n_n, 1'b1);
            chk("pdown", 16'h0000, 16'(pdown));
        end
        $display("hold done");
    endtask
    task automatic t_dma;
        int n;
        // mode bit 0 so that only the dma halt can raise the stall
        mode = 1'b0;
        hold_n = 1'b0;
        wait_lvl(surrender_acknowledge_n_n, 1'b0);
        host_n = 1'b0;
        for (n = 0; n < 10 && gnt !== 1'b1; n++) nc(1);
        chk("grant clk", 16'h0003, 16'(n));
        chk("halt", 16'h0001, 16'(stall));
        // host starts only once grant is shown
        dma_req = '{1'b1, 1'b1, 16'h0005, 16'hBEEF};
        nc(1);
        dma_req = '{1'b1, 1'b1, 16'h0006, 16'h0F0F};
        nc(1);
        dma_req = '{1'b1, 1'b0, 16'h0005, 16'h0000};
        nc(1);
        chk("dma rd", 16'hBEEF, dma_rd);
        dma_req = '{1'b1, 1'b0, 16'h0006, 16'h0000};
        nc(1);
        chk("dma rd", 16'h0F0F, dma_rd);
        dma_req = '0;
        host_n = 1'b1;
        nc(1);
        chk("grant off", 16'h0000, 16'(gnt));
        hold_n = 1'b1;
        wait_lvl(surrender_acknowledge_n_n, 1'b1);
        ram_a = 10'h005;
        nc(1);
        chk("ram", 16'hBEEF, ram_rd);
        $display("dma done");
    endtask
    // ************************************************************
    // clock and main sequence
    // ************************************************************
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    initial begin
        nc(16);
        rst_n_i = 1'b1;
        nc(1);
        chk("idle strobe", 16'h0001, 16'(pins.external_cycle_strobe_n));
        t_spaces();
        t_waits();
        t_global();
        t_hold();
        t_dma();
        results();
    end
endmodule
